// ===== rtl/atc_defines.vh
// task-file command issue and completion: shared constants
// assumes a task-file register select of three bits, as on an ata port
`ifndef ATC_DEFINES_VH
`define ATC_DEFINES_VH

// ****************************************************
// task-file register select codes
// ****************************************************
`define ATC_A_ERR_FEAT  3'h1
`define ATC_A_SCOUNT    3'h2
`define ATC_A_SNUM      3'h3
`define ATC_A_CYL_LO    3'h4
`define ATC_A_CYL_HI    3'h5
`define ATC_A_DHEAD     3'h6
`define ATC_A_STAT_CMD  3'h7

// ****************************************************
// completion_status bit positions
// ****************************************************
`define ATC_ST_BUSY     7
`define ATC_ST_DRDY     6
`define ATC_ST_DWF      5
`define ATC_ST_DSC      4
`define ATC_ST_DRQ      3
`define ATC_ST_CORR     2
`define ATC_ST_IDX      1
`define ATC_ST_ERR      0

// ****************************************************
// error_flags bit positions
// ****************************************************
`define ATC_ER_BBK      7
`define ATC_ER_UNC      6
`define ATC_ER_MC       5
`define ATC_ER_IDNF     4
`define ATC_ER_MCR      3
`define ATC_ER_ABRT     2
`define ATC_ER_TK0      1
`define ATC_ER_AMNF     0

// ****************************************************
// drive_head_select fields
// ****************************************************
`define ATC_DH_LBA      6
`define ATC_DH_DRV      4
`define ATC_DH_ADDR_HI  3
`define ATC_DH_ADDR_LO  0

// ****************************************************
// reset values and fixed codes
// ****************************************************
`define ATC_RST_BYTE    8'h00
`define ATC_RST_NIBBLE  4'h0
`define ATC_RST_ADDR    28'h0000000
`define ATC_RST_COUNT   8'h01
`define ATC_RST_SNUM    8'h01
`define ATC_COUNT_FULL  9'h100
`define ATC_COUNT_ZERO  8'h00
`define ATC_READ_NONE   8'h00

`endif

// ===== rtl/atc_tf_reg.v
// one task-file parameter register
// assumes host writes and completion loads never coincide; load wins anyway
module atc_tf_reg #(
   parameter       W   = 8,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // clock and reset
   input  wire         clk,
   input  wire         rst_b,
   // host side
   input  wire         host_we,
   input  wire [W-1:0] host_data,
   // completion side
   input  wire         load_en,
   input  wire [W-1:0] load_data,
   // value
   output wire [W-1:0] value
);

   reg [W-1:0] val_q;
   reg [W-1:0] val_d;

   // completion report overrides a host write in the same cycle
   always @* begin
      val_d = val_q;
      if (load_en) begin
         val_d = load_data;
      end else if (host_we) begin
         val_d = host_data;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         val_q <= RST;
      end else begin
         val_q <= val_d;
      end
   end

   assign value = val_q;

endmodule

// ===== rtl/atc_taskfile.v
// task-file registers with command issue and completion update
// assumes the host port and the media engine run on clk (25 MHz)
// Notes on behaviour
// - command write starts execution with the task-file values of that instant.
// - drive/head bits 7 and 5 are ignored by the device.
// - at completion busy, write fault, data request, index read zero.
// - at completion drive ready and seek complete read one.
// - corrected-data and error status flags follow the command outcome.
// - error register clears to zero when a command write arrives.
// - error register means something only when status error flag is one.
// - media change, change request, track zero, address mark errors always zero.
// - bad block, uncorrectable, not found, aborted follow the outcome.
// - completion loads address registers with last good sector address.
// - sector count zero means 256 sectors.
// - fields not affected keep their previous value after completion.
// - valid fields reflect the real result of the command.
`include "atc_defines.vh"

module atc_taskfile (
   // clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // host task-file port
   input  wire [2:0]  tf_addr,
   input  wire        tf_wr,
   input  wire [7:0]  tf_wr_data,
   output wire [7:0]  tf_rd_data,
   // command issue to the media engine
   output wire        cmd_start,
   output wire [7:0]  cmd_code,
   output wire [7:0]  cmd_features,
   output wire [8:0]  cmd_count,
   output wire [27:0] cmd_addr,
   output wire        cmd_lba_mode,
   output wire        cmd_drive,
   output wire        cmd_busy,
   // completion report from the media engine
   input  wire        done,
   input  wire        done_corr,
   input  wire        done_err,
   input  wire        done_bad_block,
   input  wire        done_uncorr,
   input  wire        done_not_found,
   input  wire        done_aborted,
   input  wire [27:0] done_last_addr,
   input  wire [7:0]  done_left
);

   // ****************************************************
   // host write decode
   // ****************************************************
   reg         busy_q;
   reg         busy_d;
   wire        host_ok;
   wire        wr_feat;
   wire        wr_scnt;
   wire        wr_snum;
   wire        wr_cyl_lo;
   wire        wr_cyl_hi;
   wire        wr_dhead;
   wire        wr_cmd;
   wire        complete;

   // parameter writes during a command would corrupt its completion report,
   // so they are dropped while busy
   assign host_ok   = tf_wr & ~busy_q;
   assign wr_feat   = host_ok & (tf_addr == `ATC_A_ERR_FEAT);
   assign wr_scnt   = host_ok & (tf_addr == `ATC_A_SCOUNT);
   assign wr_snum   = host_ok & (tf_addr == `ATC_A_SNUM);
   assign wr_cyl_lo = host_ok & (tf_addr == `ATC_A_CYL_LO);
   assign wr_cyl_hi = host_ok & (tf_addr == `ATC_A_CYL_HI);
   assign wr_dhead  = host_ok & (tf_addr == `ATC_A_DHEAD);
   assign wr_cmd    = host_ok & (tf_addr == `ATC_A_STAT_CMD);
   // a report with no command running is stale and dropped
   assign complete  = done & busy_q;

   // ****************************************************
   // parameter registers
   // ****************************************************
   wire [7:0]  sector_count;
   wire [7:0]  sector_number;
   wire [7:0]  cylinder_low;
   wire [7:0]  cylinder_high;
   wire [3:0]  dh_addr;
   reg  [7:0]  feature_select_q;
   reg  [7:0]  dh_upper_q;

   // remaining count only carries meaning after an error, loaded always
   atc_tf_reg #(
      .W         (8),
      .RST       (`ATC_RST_COUNT)
   ) u_scount (
      .clk       (clk),
      .rst_b     (rst_b),
      .host_we   (wr_scnt),
      .host_data (tf_wr_data),
      .load_en   (complete),
      .load_data (done_left),
      .value     (sector_count)
   );

   atc_tf_reg #(
      .W         (8),
      .RST       (`ATC_RST_SNUM)
   ) u_snum (
      .clk       (clk),
      .rst_b     (rst_b),
      .host_we   (wr_snum),
      .host_data (tf_wr_data),
      .load_en   (complete),
      .load_data (done_last_addr[7:0]),
      .value     (sector_number)
   );

   atc_tf_reg #(
      .W         (8),
      .RST       (`ATC_RST_BYTE)
   ) u_cyl_lo (
      .clk       (clk),
      .rst_b     (rst_b),
      .host_we   (wr_cyl_lo),
      .host_data (tf_wr_data),
      .load_en   (complete),
      .load_data (done_last_addr[15:8]),
      .value     (cylinder_low)
   );

   atc_tf_reg #(
      .W         (8),
      .RST       (`ATC_RST_BYTE)
   ) u_cyl_hi (
      .clk       (clk),
      .rst_b     (rst_b),
      .host_we   (wr_cyl_hi),
      .host_data (tf_wr_data),
      .load_en   (complete),
      .load_data (done_last_addr[23:16]),
      .value     (cylinder_high)
   );

   // low nibble of drive/head is the only part completion rewrites
   atc_tf_reg #(
      .W         (4),
      .RST       (`ATC_RST_NIBBLE)
   ) u_dh_addr (
      .clk       (clk),
      .rst_b     (rst_b),
      .host_we   (wr_dhead),
      .host_data (tf_wr_data[`ATC_DH_ADDR_HI:`ATC_DH_ADDR_LO]),
      .load_en   (complete),
      .load_data (done_last_addr[27:24]),
      .value     (dh_addr)
   );

   // upper drive/head bits and features are host-owned; completion
   // leaves them alone; the upper bits read back as last written, features are never read back
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         feature_select_q <= `ATC_RST_BYTE;
         dh_upper_q       <= `ATC_RST_BYTE;
      end else begin
         if (wr_feat) begin
            feature_select_q <= tf_wr_data;
         end
         if (wr_dhead) begin
            dh_upper_q <= tf_wr_data;
         end
      end
   end

   // ****************************************************
   // command capture
   // ****************************************************
   reg  [7:0]  code_q;
   reg  [7:0]  feat_q;
   reg  [8:0]  count_q;
   reg  [27:0] addr_q;
   reg         lba_q;
   reg         drv_q;
   reg         start_q;
   wire [8:0]  count_now;

   // zero in sector count asks for a full 256 sectors
   assign count_now = (sector_count == `ATC_COUNT_ZERO) ? `ATC_COUNT_FULL :
                      {1'b0, sector_count};

   // snapshot taken at the command write; later host writes cannot
   // reach a running command
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         code_q  <= `ATC_RST_BYTE;
         feat_q  <= `ATC_RST_BYTE;
         count_q <= `ATC_COUNT_FULL;
         addr_q  <= `ATC_RST_ADDR;
         lba_q   <= 1'b0;
         drv_q   <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= wr_cmd;
         if (wr_cmd) begin
            code_q  <= tf_wr_data;
            feat_q  <= feature_select_q;
            count_q <= count_now;
            addr_q  <= {dh_addr, cylinder_high, cylinder_low, sector_number};
            // bits 7 and 5 never reach the engine
            lba_q   <= dh_upper_q[`ATC_DH_LBA];
            drv_q   <= dh_upper_q[`ATC_DH_DRV];
         end
      end
   end

   // ****************************************************
   // busy, status and error state
   // ****************************************************
   reg         corr_q;
   reg         corr_d;
   reg         err_q;
   reg         err_d;
   reg  [7:0]  error_flags_q;
   reg  [7:0]  error_flags_d;
   wire [7:0]  completion_status;

   // busy rises on the command write and falls on the same edge that
   // loads every completion register, so nothing is half-updated
   always @* begin
      busy_d        = busy_q;
      corr_d        = corr_q;
      err_d         = err_q;
      error_flags_d = error_flags_q;
      if (wr_cmd) begin
         busy_d        = 1'b1;
         corr_d        = 1'b0;
         err_d         = 1'b0;
         error_flags_d = `ATC_RST_BYTE;
      end else if (complete) begin
         busy_d        = 1'b0;
         corr_d        = done_corr;
         err_d         = done_err;
         error_flags_d = `ATC_RST_BYTE;
         error_flags_d[`ATC_ER_BBK]  = done_bad_block;
         error_flags_d[`ATC_ER_UNC]  = done_uncorr;
         error_flags_d[`ATC_ER_IDNF] = done_not_found;
         error_flags_d[`ATC_ER_ABRT] = done_aborted;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q        <= 1'b0;
         corr_q        <= 1'b0;
         err_q         <= 1'b0;
         error_flags_q <= `ATC_RST_BYTE;
      end else begin
         busy_q        <= busy_d;
         corr_q        <= corr_d;
         err_q         <= err_d;
         error_flags_q <= error_flags_d;
      end
   end

   // fault, data request and index are never raised by this block
   assign completion_status[`ATC_ST_BUSY] = busy_q;
   assign completion_status[`ATC_ST_DRDY] = 1'b1;
   assign completion_status[`ATC_ST_DWF]  = 1'b0;
   assign completion_status[`ATC_ST_DSC]  = 1'b1;
   assign completion_status[`ATC_ST_DRQ]  = 1'b0;
   assign completion_status[`ATC_ST_CORR] = corr_q;
   assign completion_status[`ATC_ST_IDX]  = 1'b0;
   assign completion_status[`ATC_ST_ERR]  = err_q;

   // ****************************************************
   // host read path
   // ****************************************************
   reg  [7:0]  rd_data_q;
   reg  [7:0]  rd_data_d;

   // registered mux: read data follows the select one cycle later;
   // error bits are shown as stored, the host judges them by status
   always @* begin
      case (tf_addr)
         `ATC_A_ERR_FEAT: rd_data_d = error_flags_q;
         `ATC_A_SCOUNT:   rd_data_d = sector_count;
         `ATC_A_SNUM:     rd_data_d = sector_number;
         `ATC_A_CYL_LO:   rd_data_d = cylinder_low;
         `ATC_A_CYL_HI:   rd_data_d = cylinder_high;
         `ATC_A_DHEAD:    rd_data_d = {dh_upper_q[7:4], dh_addr};
         `ATC_A_STAT_CMD: rd_data_d = completion_status;
         default:         rd_data_d = `ATC_READ_NONE;
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= `ATC_READ_NONE;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign tf_rd_data   = rd_data_q;
   assign cmd_start    = start_q;
   assign cmd_code     = code_q;
   assign cmd_features = feat_q;
   assign cmd_count    = count_q;
   assign cmd_addr     = addr_q;
   assign cmd_lba_mode = lba_q;
   assign cmd_drive    = drv_q;
   assign cmd_busy     = busy_q;

endmodule

// ===== sim/atc_monitor.sv
// checker for the task-file command block, bound to its top module
// assumes clk is the only clock and rst_b the asynchronous reset
module atc_monitor (
   // clock and reset
   input logic       clk,
   input logic       rst_b,
   // host port
   input logic [2:0] tf_addr,
   input logic       tf_wr,
   input logic [7:0] tf_rd_data,
   // command side
   input logic       cmd_start,
   input logic [7:0] cmd_code,
   input logic [8:0] cmd_count,
   input logic       cmd_busy,
   input logic       done
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************
   // issue and completion
   // ************************
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // a command write that the block may take; busy refuses it
   wire issue = tf_wr && tf_addr == 3'h7 && !cmd_busy;
   a_issue_starts: assert property (issue |=> cmd_start && cmd_busy) else $error("no start");
   a_start_pulse: assert property (cmd_start |=> !cmd_start) else $error("start too long");
   a_capture_holds: assert property (!issue |=> $stable(cmd_code) && $stable(cmd_count))
      else $error("captured command moved");
   a_count_range: assert property (cmd_start |-> cmd_count != 9'h000 && cmd_count <= 9'h100)
      else $error("count out of range");
   a_busy_holds: assert property (cmd_busy && !done |=> cmd_busy) else $error("busy dropped");
   a_busy_ends: assert property (cmd_busy && done |=> !cmd_busy) else $error("busy stuck");
   // status is read one edge late, so busy is compared with its past value
   a_status_fixed: assert property (tf_addr == 3'h7 |=> tf_rd_data[6:3] == 4'ha && !tf_rd_data[1]
      && tf_rd_data[7] == $past(cmd_busy)) else $error("status fixed bits wrong");
   a_error_cleared: assert property (issue ##1 tf_addr == 3'h1 |=> tf_rd_data == 8'h00)
      else $error("error not cleared");
   a_media_zero: assert property (tf_addr == 3'h1 |=> (tf_rd_data & 8'h2b) == 8'h00)
      else $error("media error bits set");
   c_issue: cover property (issue);
   c_finish: cover property (cmd_busy && done);
   c_full_count: cover property (cmd_start && cmd_count == 9'h100);
endmodule
bind atc_taskfile atc_monitor atc_monitor_inst (.clk, .rst_b, .tf_addr, .tf_wr, .tf_rd_data, .cmd_start,
   .cmd_code, .cmd_count, .cmd_busy, .done);

// ===== sim/atc_host_model.sv
// host controller model for the task-file port
// assumes callers enter its tasks just after a rising edge of clk
module atc_host_model (
   // clock
   input  logic       clk,
   // task-file port
   output logic [2:0] tf_addr,
   output logic       tf_wr,
   output logic [7:0] tf_wr_data,
   input  logic [7:0] tf_rd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************
   // bus cycles
   // ************************
   // idle bus at time zero
   initial begin
      tf_addr = 3'h0;
      tf_wr = 1'b0;
      tf_wr_data = 8'h00;
   end
   // one write; a write followed by another keeps the strobe up, so no signal
   // is set twice in one step; the last one releases it with inverted data
   task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic last);
      tf_addr = a;
      tf_wr_data = d;
      tf_wr = 1'b1;
      @(posedge clk);
      #1;
      if (last) begin
         tf_wr = 1'b0;
         tf_wr_data = ~d;
      end
   endtask
   // read data is registered, so it is taken one edge after selection
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      tf_addr = a;
      @(posedge clk);
      #1;
      v = tf_rd_data;
   endtask
   // parameters first, command last; u sets the unused drive/head bits
   task automatic issue(input logic [7:0] c, f, s, input logic [27:0] ad, input logic l, dr,
                        input logic [1:0] u);
      wr(3'h1, f, 1'b0);
      wr(3'h2, s, 1'b0);
      wr(3'h3, ad[7:0], 1'b0);
      wr(3'h4, ad[15:8], 1'b0);
      wr(3'h5, ad[23:16], 1'b0);
      wr(3'h6, {u[1], l, u[0], dr, ad[27:24]}, 1'b0);
      wr(3'h7, c, 1'b1);
   endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the task-file command block
// assumes the host model drives the port and this bench plays the media engine
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_b, done;
   logic [2:0]  tf_addr;
   logic        tf_wr, cmd_start, cmd_lba_mode, cmd_drive, cmd_busy;
   logic [7:0]  tf_wr_data, tf_rd_data, cmd_code, cmd_features, done_left;
   logic [8:0]  cmd_count;
   logic [27:0] cmd_addr, done_last_addr;
   logic [5:0]  oc;
   wire         done_corr, done_err, done_bad_block, done_uncorr, done_not_found, done_aborted;
   int          fail_count, cmp_count;
   logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h50};
   assign {done_corr, done_err, done_bad_block, done_uncorr, done_not_found, done_aborted} = oc;
   // ************************
   // design and host
   // ************************
   atc_taskfile atc_taskfile_inst (.clk, .rst_b, .tf_addr, .tf_wr, .tf_wr_data, .tf_rd_data, .cmd_start,
      .cmd_code, .cmd_features, .cmd_count, .cmd_addr, .cmd_lba_mode, .cmd_drive, .cmd_busy, .done,
      .done_corr, .done_err, .done_bad_block, .done_uncorr, .done_not_found, .done_aborted,
      .done_last_addr, .done_left);
   atc_host_model host (.clk, .tf_addr, .tf_wr, .tf_wr_data, .tf_rd_data);
   // ************************
   // checking helpers
   // ************************
   task automatic check(input string n, input logic [27:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   function automatic logic [7:0] exp_status(input logic [5:0] o);
      return 8'h50 | {5'h00, o[5], 1'b0, o[4]};
   endfunction
   function automatic logic [7:0] exp_error(input logic [5:0] o);
      return {o[3], o[2], 1'b0, o[1], 1'b0, o[0], 2'b00};
   endfunction
   function automatic logic [8:0] exp_count(input logic [7:0] s);
      return (s == 8'h00) ? 9'h100 : {1'b0, s};
   endfunction
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // watchdog: the whole run needs well under 1000 cycles
   initial begin
      #100000;
      fail_count++;
      summarize();
   end
   // ************************
   // tests
   // ************************
   initial begin
      logic [7:0]  v, c, f, s, lft;
      logic [27:0] ad, la;
      logic [5:0]  o;
      logic [1:0]  u;
      logic        l, dr;
      rst_b = 1'b0;
      done = 1'b0;
      oc = 6'h00;
      done_last_addr = 28'h0000000;
      done_left = 8'h00;
      v = 8'($urandom(32'hd053c46d));
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      // a completion while idle must be ignored
      oc = 6'h3f;
      done_last_addr = 28'h5a5a5a5;
      done_left = 8'h77;
      done = 1'b1;
      @(posedge clk);
      #1 done = 1'b0;
      foreach (rv[i]) begin
         host.rd(3'(i), v);
         check("reset value", v, rv[i]);
      end
      $display("test reset values done");
      // random commands; the first two hit the count boundaries
      for (int k = 0; k < 8; k++) begin
         c = 8'($urandom);
         f = 8'($urandom);
         ad = 28'($urandom);
         s = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
         u = (k < 2) ? 2'b11 : 2'($urandom);
         l = 1'($urandom);
         dr = 1'($urandom);
         host.issue(c, f, s, ad, l, dr, u);
         check("start", cmd_start, 1'b1);
         check("code", cmd_code, c);
         check("features", cmd_features, f);
         check("count", cmd_count, exp_count(s));
         check("address", cmd_addr, ad);
         check("mode drive", {cmd_lba_mode, cmd_drive}, {l, dr});
         host.rd(3'h1, v);
         check("error on issue", v, 8'h00);
         // writes while busy are dropped, command included
         host.wr(3'h6, {~u[1], ~l, ~u[0], ~dr, 4'h0}, 1'b0);
         host.wr(3'h7, ~c, 1'b1);
         check("busy command", cmd_code, c);
         // random idle gap; each wait ends just after an edge like every other drive
         repeat ($urandom_range(0, 5)) begin
            @(posedge clk);
            #1;
         end
         host.rd(3'h7, v);
         check("busy status", v, 8'hd0);
         o = 6'($urandom);
         la = 28'($urandom);
         lft = 8'($urandom);
         oc = o;
         done_last_addr = la;
         done_left = lft;
         done = 1'b1;
         @(posedge clk);
         #1 done = 1'b0;
         oc = ~o;
         done_last_addr = ~la;
         done_left = ~lft;
         check("busy released", cmd_busy, 1'b0);
         host.rd(3'h7, v);
         check("status", v, exp_status(o));
         host.rd(3'h1, v);
         check("error", v, exp_error(o));
         host.rd(3'h2, v);
         check("left count", v, lft);
         for (int i = 0; i < 3; i++) begin
            host.rd(3'(i + 3), v);
            check("last address", v, la[i*8 +: 8]);
         end
         host.rd(3'h6, v);
         check("drive head", v, {u[1], l, u[0], dr, la[27:24]});
         $display("test command %0d done", k);
      end
      summarize();
   end
endmodule
